// [core/bcs_breaker_ctrl.sv]
/*
  breaker control and position status: open/close command gating, pole
  position derivation, bad-status and pole-discrepancy timers, operation
  counter and change events.
  assumes all inputs are synchronous to core_clk and already selected.
*/
// How it works
// - combined option ORs trips into open
// - per-pole external trips reach pole reporting
// - external open input drives open relay
// - block-open suppresses every open command
// - external close input drives close relay
// - autoreclose close passes only when supervised
// - block-close suppresses every close command
// - local input inhibits interlocked open and close
// - mode picks one or three pole inputs
// - closed indication from normally-open contact
// - opened from normally-closed, or inverted closed
// - in one-pole mode phase b and c inputs give poles b and c
// - both indications off runs bad-status timer
// - pole disagreement runs discrepancy timer
// - counter reset clears operation counter
// - events enabled logs state changes
// - disabled function forces relay, trip, position and alarm outputs off; op_count holds unless counter_reset clears it
// - substitution replaces derived position
`timescale 1ns/1ps
module bcs_breaker_ctrl
    import bcs_pkg::*;
#(
    parameter int OPS_WIDTH = OPS_W
)
(
    input wire logic core_clk,
    input wire logic rstn,
    // settings
    input wire logic function_en,
    input wire logic combined_en,
    input wire logic substitution_en,
    input wire logic events_en,
    input wire bcs_mode_t indication_mode,
    input wire logic [2:0] opened_from_inverse,
    input wire logic [10:0] operate_time_ms,
    input wire logic [10:0] discrepancy_time_ms,
    input wire logic [1:0] subst_position,
    // commands
    input wire logic [2:0] trip_scheme,
    input wire logic [2:0] ext_trip,
    input wire logic ext_open,
    input wire logic block_open,
    input wire logic ext_close,
    input wire logic ar_close,
    input wire logic sync_check_permit,
    input wire logic block_close,
    input wire logic local_input,
    input wire logic counter_reset,
    // contacts, index 0 = pole a / three-pole
    input wire logic [2:0] breaker_aux_closed_contact,
    input wire logic [2:0] breaker_aux_open_contact,
    // outputs
    output logic open_relay,
    output logic close_relay,
    output logic [2:0] trip_report,
    output logic [2:0] pole_closed,
    output logic [2:0] pole_opened,
    output logic three_pole_closed,
    output logic three_pole_opened,
    output logic bad_status,
    output logic discrepancy_alarm,
    output logic [OPS_WIDTH-1:0] op_count,
    output logic event_valid,
    output logic [EVT_W-1:0] event_data
);
    // ----------------------------------------
    // command gating
    // ----------------------------------------
    wire trip_any = |trip_scheme;
    wire open_req = ext_open | (combined_en & trip_any);
    wire open_ok = function_en & ~block_open & ~local_input;
    wire next_open = open_req & open_ok;
    wire ar_ok = ar_close & sync_check_permit;
    wire close_req = ext_close | ar_ok;
    wire close_ok = function_en & ~block_close & ~local_input;
    // open wins if both pass their gates: never drive both coils together
    wire next_close = close_req & close_ok & ~next_open;
    wire [2:0] next_trip_report = function_en ? ext_trip : 3'h0;

    // ----------------------------------------
    // position derivation per pole
    // ----------------------------------------
    logic [2:0] raw_closed; // contact closed indication
    logic [2:0] raw_opened; // contact opened indication
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_pole
            // three-pole mode copies pole a onto all poles
            wire logic src = (indication_mode == BCS_MODE_3POLE) ? 1'b0 : 1'b1;
            wire logic cl = src ? breaker_aux_closed_contact[p]
                                : breaker_aux_closed_contact[0];
            wire logic op = src ? breaker_aux_open_contact[p]
                                : breaker_aux_open_contact[0];
            wire logic inv = src ? opened_from_inverse[p] : opened_from_inverse[0];
            assign raw_closed[p] = cl;
            assign raw_opened[p] = inv ? ~cl : op;
        end
    endgenerate

    // substitution forces every pole to the entered position
    wire subst_closed = (subst_position == BCS_POS_CLOSED);
    wire subst_opened = (subst_position == BCS_POS_OPEN);
    wire [2:0] sel_closed = substitution_en ? {3{subst_closed}} : raw_closed;
    wire [2:0] sel_opened = substitution_en ? {3{subst_opened}} : raw_opened;
    wire [2:0] next_closed = function_en ? sel_closed & ~sel_opened : 3'h0;
    wire [2:0] next_opened = function_en ? sel_opened & ~sel_closed : 3'h0;
    wire next_3p_closed = &next_closed;
    wire next_3p_opened = &next_opened;

    // ----------------------------------------
    // timers
    // ----------------------------------------
    bcs_tmr_if op_t ();   // bad-status timer
    bcs_tmr_if disc_t (); // pole discrepancy timer
    // runs while any pole shows neither contact; a stuck both-on does not qualify
    assign op_t.run = function_en & (|(~sel_closed & ~sel_opened));
    assign op_t.ms = operate_time_ms;
    // the user is expected to set this to the breaker's own operating time
    wire poles_agree = next_3p_closed | next_3p_opened;
    assign disc_t.run = function_en & ~poles_agree;
    assign disc_t.ms = discrepancy_time_ms;

    bcs_delay_timer u_op_tmr (
        .core_clk(core_clk),
        .rstn(rstn),
        .t(op_t)
    );
    bcs_delay_timer u_disc_tmr (
        .core_clk(core_clk),
        .rstn(rstn),
        .t(disc_t)
    );

    // ----------------------------------------
    // operation counter
    // ----------------------------------------
    // a transition completes when the opposite settled state is reached,
    // so a bad-status interval in between does not double count
    logic last_settled_closed; // last settled three-pole state
    logic settled_valid;       // a settled state has been seen
    wire to_closed = next_3p_closed & settled_valid & ~last_settled_closed;
    wire to_opened = next_3p_opened & settled_valid & last_settled_closed;
    wire op_done = to_closed | to_opened;

    // ----------------------------------------
    // event word
    // ----------------------------------------
    wire [EVT_W-1:0] next_state_word = {next_open, next_close, next_3p_closed, next_3p_opened,
                                        op_t.expired, disc_t.expired, 1'b0, function_en};
    logic [EVT_W-1:0] prev_state_word; // snapshot from the previous cycle, kept whether or not events are on

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            open_relay <= 1'b0;
            close_relay <= 1'b0;
            trip_report <= 3'h0;
            pole_closed <= 3'h0;
            pole_opened <= 3'h0;
            three_pole_closed <= 1'b0;
            three_pole_opened <= 1'b0;
            bad_status <= 1'b0;
        end else begin
            open_relay <= next_open;
            close_relay <= next_close;
            trip_report <= next_trip_report;
            pole_closed <= next_closed;
            pole_opened <= next_opened;
            three_pole_closed <= next_3p_closed;
            three_pole_opened <= next_3p_opened;
            bad_status <= op_t.expired & function_en;
        end
    end

    // alarm latches on expiry and clears once the poles agree or the function is disabled
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            discrepancy_alarm <= 1'b0;
        end else if (!function_en || poles_agree) begin
            discrepancy_alarm <= 1'b0;
        end else if (disc_t.expired) begin
            discrepancy_alarm <= 1'b1;
        end
    end

    // counter: reset input has priority over a coincident transition
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            op_count <= OPS_WIDTH'(OPS_RESET);
            last_settled_closed <= 1'b0;
            settled_valid <= 1'b0;
        end else begin
            if (counter_reset) begin
                op_count <= OPS_WIDTH'(OPS_RESET);
            end else if (op_done) begin
                op_count <= op_count + OPS_WIDTH'(1);
            end
            if (next_3p_closed | next_3p_opened) begin
                last_settled_closed <= next_3p_closed;
                settled_valid <= 1'b1;
            end
        end
    end

    // change logger: one pulse per changed snapshot while events are on
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_state_word <= '0;
            event_valid <= 1'b0;
            event_data <= '0;
        end else begin
            prev_state_word <= next_state_word;
            event_valid <= events_en && (next_state_word != prev_state_word);
            event_data <= next_state_word;
        end
    end
endmodule // bcs_breaker_ctrl

// [core/bcs_pkg.sv]
/*
  package for the breaker control and status block: timing constants, reset
  values, indication modes and the shape of the event record.
  assumes a 40 mhz core clock and a millisecond setting grain.
*/
package bcs_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 40000000;           // core clock rate
    localparam int TICK_US = 1000;              // setting grain in us (0.001 s step)
    localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US; // cycles per ms step
    localparam int TMR_MS_MAX = 2000;           // longest setting, 2.000 s
    localparam logic [10:0] OP_TIME_DEFAULT = 11'h046;   // 0.070 s
    localparam logic [10:0] DISC_TIME_DEFAULT = 11'h046; // 0.070 s
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    // ----------------------------------------
    // counters and events
    // ----------------------------------------
    localparam int OPS_W = 16;                  // operation counter width
    localparam logic [15:0] OPS_RESET = 16'h0000;
    localparam int EVT_W = 8;                   // event word width

    // indication mode
    typedef enum logic {BCS_MODE_3POLE, BCS_MODE_1POLE} bcs_mode_t;
    // derived position
    typedef enum logic [1:0] {BCS_POS_OPEN, BCS_POS_CLOSED, BCS_POS_BAD, BCS_POS_MID} bcs_pos_t;
endpackage

// [core/bcs_tmr_if.sv]
/*
  interface carrying a run level, a setting and the expiry flag between the
  top module and its delay timers. assumes one shared clock.
*/
`timescale 1ns/1ps
interface bcs_tmr_if;
    logic run;          // timer runs while high, clears when low
    logic [10:0] ms;    // delay setting in ms
    logic expired;      // high once the delay has elapsed
    modport owner (output run, output ms, input expired);
    modport timer (input run, input ms, output expired);
endinterface // bcs_tmr_if

// [core/bcs_delay_timer.sv]
/*
  pickup timer in millisecond steps: counts while run is high, reports
  expiry, clears at once when run drops. assumes synchronous run input.
*/
`timescale 1ns/1ps
module bcs_delay_timer
    import bcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    bcs_tmr_if.timer t
);
    logic [15:0] sub;   // cycles within the current ms step
    logic [10:0] ms_cnt; // elapsed whole ms
    wire tick = (sub == TICK_LAST);
    wire done = (ms_cnt >= t.ms);

    // ----------------------------------------
    // count
    // ----------------------------------------
    // zero setting expires one cycle after run rises
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sub <= 16'h0000;
            ms_cnt <= 11'h000;
            t.expired <= 1'b0;
        end else if (!t.run) begin
            sub <= 16'h0000;
            ms_cnt <= 11'h000;
            t.expired <= 1'b0;
        end else begin
            sub <= tick ? 16'h0000 : sub + 16'h0001;
            if (tick && !done) begin
                ms_cnt <= ms_cnt + 11'h001;
            end
            t.expired <= done;
        end
    end
endmodule // bcs_delay_timer

// [testbench/bcs_breaker_ctrl_chk.sv]
/*
  assertion checker for the breaker control block, bound to its top.
  assumes one clock domain and the registered one-cycle answer.
*/
`timescale 1ns/1ps
module bcs_breaker_ctrl_chk
    import bcs_pkg::*;
#(parameter int OPS_WIDTH = OPS_W)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic function_en,
    input wire logic combined_en,
    input wire logic [2:0] trip_scheme,
    input wire logic ext_open,
    input wire logic block_open,
    input wire logic ext_close,
    input wire logic ar_close,
    input wire logic sync_check_permit,
    input wire logic block_close,
    input wire logic local_input,
    input wire logic counter_reset,
    input wire logic open_relay,
    input wire logic close_relay,
    input wire logic [OPS_WIDTH-1:0] op_count
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire op_req = ext_open | (combined_en & |trip_scheme); // any open request
    wire cl_ok = function_en & !op_req & !block_close & !local_input; // open wins over close
    property p_open_pass;
        $past(rstn && function_en && ext_open && !block_open && !local_input) |-> open_relay;
    endproperty
    property p_trip_or;
        $past(rstn && function_en && !ext_open && !block_open && !local_input)
            |-> open_relay == $past(combined_en && |trip_scheme);
    endproperty
    property p_block_open;
        $past(block_open) |-> !open_relay;
    endproperty
    property p_close_pass;
        $past(rstn && cl_ok && ext_close) |-> close_relay;
    endproperty
    property p_ar_supv;
        $past(rstn && cl_ok && !ext_close && ar_close) |-> close_relay == $past(sync_check_permit);
    endproperty
    property p_block_close;
        $past(block_close) |-> !close_relay;
    endproperty
    property p_local;
        $past(local_input) |-> !open_relay && !close_relay;
    endproperty
    property p_off;
        $past(!function_en) |-> !open_relay && !close_relay;
    endproperty
    property p_cnt_rst;
        $past(counter_reset) |-> op_count == '0;
    endproperty
    a_open_pass: assert property (p_open_pass) else $error("open request not passed");
    a_trip_or: assert property (p_trip_or) else $error("trip path wrong");
    a_block_open: assert property (p_block_open) else $error("open not blocked");
    a_close_pass: assert property (p_close_pass) else $error("close request not passed");
    a_ar_supv: assert property (p_ar_supv) else $error("reclose supervision wrong");
    a_block_close: assert property (p_block_close) else $error("close not blocked");
    a_local: assert property (p_local) else $error("local input did not inhibit");
    a_off: assert property (p_off) else $error("relay on while disabled");
    a_cnt_rst: assert property (p_cnt_rst) else $error("counter not cleared");
    c_open: cover property (open_relay);
    c_close: cover property (close_relay);
    c_count: cover property (op_count != '0);
endmodule // bcs_breaker_ctrl_chk

bind bcs_breaker_ctrl bcs_breaker_ctrl_chk #(.OPS_WIDTH(OPS_WIDTH)) u_chk (.core_clk(core_clk), .rstn(rstn),
    .function_en(function_en), .combined_en(combined_en), .trip_scheme(trip_scheme), .ext_open(ext_open),
    .block_open(block_open), .ext_close(ext_close), .ar_close(ar_close), .sync_check_permit(sync_check_permit),
    .block_close(block_close), .local_input(local_input), .counter_reset(counter_reset),
    .open_relay(open_relay), .close_relay(close_relay), .op_count(op_count));

// [testbench/bcs_breaker_model.sv]
/*
  behavioural breaker: coil relays in, auxiliary contacts out.
  assumes relays are levels held until the travel is done.
*/
`timescale 1ns/1ps
module bcs_breaker_model #(parameter int TRAVEL = 4)
(
    input wire logic core_clk,
    input wire logic open_relay,
    input wire logic close_relay,
    output logic [2:0] closed_c,
    output logic [2:0] open_c
);
    logic pos = 1'b0; // main contacts, high when closed
    logic [1:0] last_coil = 2'b00; // coil pair seen at the previous edge
    int t = 0; // cycles the same coil has been energised
    wire [1:0] coil = {open_relay, close_relay};
    // travel short of the operate time so a healthy move never flags bad status;
    // a change of coil restarts travel, so a close straight after an open still moves
    always @(posedge core_clk) begin
        last_coil <= coil;
        if (coil == 2'b00 || coil != last_coil) begin
            t <= 0;
        end else begin
            t <= t + 1;
        end
        if (t == TRAVEL && coil == last_coil) begin
            pos <= (coil == 2'b01);
        end
    end
    // both contacts off in mid travel, like real auxiliaries
    assign closed_c = {3{pos && (t == 0 || t > TRAVEL)}};
    assign open_c = {3{!pos && (t == 0 || t > TRAVEL)}};
endmodule // bcs_breaker_model

// [testbench/bcs_breaker_ctrl_tb.sv]
/*
  self-checking bench for the breaker control block.
  assumes the breaker model on the contacts, or bench-driven contacts.
*/
`timescale 1ns/1ps
module bcs_breaker_ctrl_tb;
    import bcs_pkg::*;
    logic core_clk, rstn, function_en, combined_en, substitution_en, events_en, ext_open, block_open, ev;
    logic ext_close, ar_close, sync_check_permit, block_close, local_input, counter_reset, use_model;
    bcs_mode_t indication_mode;
    logic [2:0] opened_from_inverse, trip_scheme, ext_trip, tb_cc, tb_oc, m_cc, m_oc;
    logic [2:0] breaker_aux_closed_contact, breaker_aux_open_contact, trip_report, pole_closed, pole_opened;
    logic [10:0] operate_time_ms, discrepancy_time_ms;
    logic [1:0] subst_position;
    logic open_relay, close_relay, three_pole_closed, three_pole_opened, bad_status, discrepancy_alarm;
    logic event_valid;
    logic [15:0] op_count;
    logic [7:0] event_data;
    int error_cnt = 0;
    int n_tests = 0;
    // command table: comb trip eo bo ec ar sy bc lo | open close
    logic [10:0] tbl [10] = '{11'h102, 11'h602, 11'h200, 11'h180, 11'h041, 11'h031, 11'h020, 11'h048,
        11'h144, 11'h142};
    // ----------------------------------------
    // clock, parts and helpers
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    assign breaker_aux_closed_contact = use_model ? m_cc : tb_cc;
    assign breaker_aux_open_contact = use_model ? m_oc : tb_oc;
    bcs_breaker_ctrl dut (.*);
    bcs_breaker_model u_bkr (.core_clk(core_clk), .open_relay(open_relay), .close_relay(close_relay),
        .closed_c(m_cc), .open_c(m_oc));
    task automatic go(int n); // let n edges land, then look
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmd(logic [1:0] oc); // plain open/close request, other open/close command inputs off
        @(posedge core_clk);
        {combined_en, trip_scheme, block_open, ar_close, sync_check_permit, block_close} <= 8'h00;
        local_input <= 1'b0;
        {ext_open, ext_close} <= oc;
    endtask
    task automatic evt(output logic s); // any event pulse in a short window
        s = 1'b0;
        repeat (4) begin
            @(negedge core_clk);
            s = s | event_valid;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin // watchdog, run needs well under a thousand cycles
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        rstn = 1'b0; function_en = 1'b1; substitution_en = 1'b0; events_en = 1'b1; use_model = 1'b1;
        {combined_en, ext_open, block_open, ext_close, ar_close, sync_check_permit} = 6'h00;
        {block_close, local_input, counter_reset} = 3'h0;
        indication_mode = BCS_MODE_3POLE; opened_from_inverse = 3'h0; trip_scheme = 3'h0; ext_trip = 3'h0;
        tb_cc = 3'h0; tb_oc = 3'h0; subst_position = 2'h0;
        operate_time_ms = 11'h001; discrepancy_time_ms = 11'h001; // longer than model travel
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            combined_en <= tbl[i][10];
            {ext_open, block_open, ext_close, ar_close, sync_check_permit} <= tbl[i][8:4];
            {block_close, local_input} <= tbl[i][3:2];
            trip_scheme <= {3{tbl[i][9]}};
            go(1);
            chk("relays", {open_relay, close_relay}, tbl[i][1:0]);
        end
        cmd(2'h2); go(12); chk("opened", {three_pole_opened, pole_opened}, 4'hf);
        @(posedge core_clk); counter_reset <= 1'b1; go(1); chk("cnt clr", op_count, 16'h0000);
        @(posedge core_clk); counter_reset <= 1'b0;
        cmd(2'h1); go(12); chk("closed", {three_pole_closed, pole_closed}, 4'hf);
        chk("count close", op_count, 16'h0001);
        cmd(2'h2); go(12); chk("count open", op_count, 16'h0002);
        @(posedge core_clk); ext_trip <= 3'h5; go(1); chk("trip rep", trip_report, 16'h0005);
        cmd(2'h0); use_model <= 1'b0; operate_time_ms <= 11'h000; discrepancy_time_ms <= 11'h000;
        tb_cc <= 3'h6; go(6); chk("bad", bad_status, 16'h0001);
        chk("3p uses pole a", pole_closed, 16'h0000);
        @(posedge core_clk); indication_mode <= BCS_MODE_1POLE; tb_oc <= 3'h1; go(6);
        chk("1p poles", {pole_closed, pole_opened}, 16'h0031);
        chk("disc", discrepancy_alarm, 16'h0001);
        chk("bad clr", bad_status, 16'h0000);
        @(posedge core_clk); tb_cc <= 3'h7; tb_oc <= 3'h0; go(3);
        chk("disc clr", discrepancy_alarm, 16'h0000);
        @(posedge core_clk); opened_from_inverse <= 3'h7; tb_cc <= 3'h1; go(3);
        chk("inv opened", pole_opened, 16'h0006);
        @(posedge core_clk); substitution_en <= 1'b1; subst_position <= 2'h1; go(3);
        chk("subst closed", {three_pole_closed, three_pole_opened}, 16'h0002);
        @(posedge core_clk); subst_position <= 2'h0; go(3);
        chk("subst open", {three_pole_closed, three_pole_opened}, 16'h0001);
        cmd(2'h2); evt(ev); chk("event on", ev, 16'h0001);
        chk("event word", event_data, 16'h0091);
        cmd(2'h0); events_en <= 1'b0; evt(ev); chk("event off", ev, 16'h0000);
        @(posedge core_clk); function_en <= 1'b0; ext_open <= 1'b1; go(3);
        chk("disabled", {open_relay, pole_closed, bad_status}, 16'h0000);
        give_verdict();
    end
endmodule // bcs_breaker_ctrl_tb
